// File: updown_counter_pkg.sv
// shared constants, types and register map of the up/down counter block
package updown_counter_pkg;

    // ------------------------------------------------------------------
    // counter geometry
    // ------------------------------------------------------------------
    localparam int          CNT_W       = 4;
    localparam logic [3:0]  CNT_TOP     = 4'hf;
    localparam logic [3:0]  CNT_BOTTOM  = 4'h0;
    localparam logic [3:0]  CNT_STEP    = 4'h1;
    localparam logic [3:0]  CNT_RST     = 4'h0;
    localparam logic        FLAG_RST    = 1'b0;
    localparam logic        PULSE_RST   = 1'b1;

    // ------------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------------
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  OFS_STATE   = 8'h00;
    localparam logic [7:0]  OFS_EVENT   = 8'h04;
    localparam logic [7:0]  OFS_CLEAR   = 8'h08;
    localparam logic [7:0]  OFS_ENABLE  = 8'h0c;

    // field positions of the live state register
    localparam int          ST_COUNT_LSB = 0;
    localparam int          ST_FLAG_BIT  = 4;
    localparam int          ST_PULSE_BIT = 5;
    localparam int          ST_DIR_BIT   = 6;
    localparam int          ST_LOAD_BIT  = 7;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

    // ------------------------------------------------------------------
    // event bits: same layout in event, clear and enable registers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic preset;
        logic cascade;
        logic terminal;
    } evt_s;

    localparam logic [2:0]  EVT_RST     = 3'h0;

    typedef enum logic [0:0] {
        W_IDLE = 1'b0,
        W_RESP = 1'b1
    } wr_state_e;

    typedef enum logic [0:0] {
        R_IDLE = 1'b0,
        R_DATA = 1'b1
    } rd_state_e;

endpackage : updown_counter_pkg

// File: level_edges.sv
// registered copy of a synchronous level with rise and fall strobes
`timescale 1ns/1ps
module level_edges (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic level,
    output logic      rise,
    output logic      fall
);

    logic prev_q;
    logic prev_d;

    always_comb begin
        prev_d = level;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
        end
    end

    // strobes are combinational so the caller reacts in the same cycle
    assign rise = level & ~prev_q;
    assign fall = ~level & prev_q;

endmodule : level_edges

// File: updown_counter.sv
// four-bit up/down counter with preset, terminal flag, cascade pulse and axi4-lite access
//
// Functional notes
// R1 - four-bit count wraps modulo sixteen both up and down
// R2 - low preset_load_n copies preset_value into the count
// R3 - preset overrides enable, direction and clock
// R4 - counting happens only on a rising count_clock edge
// R5 - count_enable_n high holds the count
// R6 - direction_sel low counts up, high counts down
// R7 - enable and direction may change at either clock level
// R8 - terminal_flag high at 15 counting up or 0 counting down
// R9 - terminal_flag is decoded from count and direction only
// R10 - terminal_flag is not gated by count_enable_n
// R11 - outside logic must not clock on terminal_flag
// R12 - enabled terminal count drives cascade_pulse_n low from clock fall to rise
// R13 - preset, disable or low flag force cascade_pulse_n high
// R14 - cascade pulse may clock the next stage in a ripple chain
// R15 - shared clock cascade needs low phase longer than carry ripple
// R16 - cascade_pulse_n returns high right after count_clock rises
// R17 - look-ahead stages build enables from earlier flags plus global enable
// R18 - after preset release counting resumes from the preset value
`timescale 1ns/1ps
module updown_counter (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        count_clock,
    input  wire logic        count_enable_n,
    input  wire logic        direction_sel,
    input  wire logic        preset_load_n,
    input  wire logic [3:0]  preset_value,
    output logic      [3:0]  count_value,
    output logic             terminal_flag,
    output logic             cascade_pulse_n,
    output logic             irq,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic is_mapped(input logic [7:0] addr);
        return (addr == updown_counter_pkg::OFS_STATE)  ||
               (addr == updown_counter_pkg::OFS_EVENT)  ||
               (addr == updown_counter_pkg::OFS_CLEAR)  ||
               (addr == updown_counter_pkg::OFS_ENABLE);
    endfunction : is_mapped

    function automatic logic flag_of(input logic [3:0] cnt, input logic down);
        return (!down && cnt == updown_counter_pkg::CNT_TOP) ||
               (down && cnt == updown_counter_pkg::CNT_BOTTOM);
    endfunction : flag_of

    // ------------------------------------------------------------------
    // clock and preset edges
    // ------------------------------------------------------------------
    logic cp_rise;
    logic cp_fall;
    logic load_fall;

    level_edges u_cp_edges (
        .clk   (clk),
        .rst_b (rst_b),
        .level (count_clock),
        .rise  (cp_rise),
        .fall  (cp_fall)
    );

    level_edges u_load_edges (
        .clk   (clk),
        .rst_b (rst_b),
        .level (preset_load_n),
        .rise  (),
        .fall  (load_fall)
    );

    // ------------------------------------------------------------------
    // counter, terminal flag and cascade pulse
    // ------------------------------------------------------------------
    logic [3:0] count_q;
    logic [3:0] count_d;
    logic       flag_q;
    logic       flag_d;
    logic       pulse_q;
    logic       pulse_d;

    always_comb begin
        count_d = count_q;
        if (!preset_load_n) begin
            count_d = preset_value;                                      // R2 R3
        end else if (cp_rise && !count_enable_n) begin                   // R4 R5 R7 R18
            if (direction_sel) begin
                count_d = count_q - updown_counter_pkg::CNT_STEP;         // R1 R6
            end else begin
                count_d = count_q + updown_counter_pkg::CNT_STEP;         // R1 R6
            end
        end
        // flag ignores the enable so look-ahead chains can gate it outside
        flag_d = flag_of(count_d, direction_sel);                        // R8 R9 R10
        pulse_d = pulse_q;
        if (!preset_load_n || count_enable_n || !flag_q) begin
            pulse_d = 1'b1;                                              // R13
        end else if (cp_fall) begin
            pulse_d = 1'b0;                                              // R12
        end else if (cp_rise) begin
            pulse_d = 1'b1;                                              // R16
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= updown_counter_pkg::CNT_RST;
            flag_q  <= updown_counter_pkg::FLAG_RST;
            pulse_q <= updown_counter_pkg::PULSE_RST;
        end else begin
            count_q <= count_d;
            flag_q  <= flag_d;
            pulse_q <= pulse_d;
        end
    end

    assign count_value     = count_q;
    assign terminal_flag   = flag_q;
    assign cascade_pulse_n = pulse_q;

    // ------------------------------------------------------------------
    // events and interrupt
    // ------------------------------------------------------------------
    updown_counter_pkg::evt_s evt_q;
    updown_counter_pkg::evt_s evt_d;
    updown_counter_pkg::evt_s ena_q;
    updown_counter_pkg::evt_s ena_d;
    updown_counter_pkg::evt_s hit;
    updown_counter_pkg::evt_s clr;
    logic                     irq_q;
    logic                     irq_d;

    // ------------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------------
    updown_counter_pkg::wr_state_e wst_q;
    updown_counter_pkg::wr_state_e wst_d;
    updown_counter_pkg::rd_state_e rst_q;
    updown_counter_pkg::rd_state_e rst_d;
    logic        aw_got_q;
    logic        aw_got_d;
    logic        w_got_q;
    logic        w_got_d;
    logic [7:0]  waddr_q;
    logic [7:0]  waddr_d;
    logic [31:0] wdata_q;
    logic [31:0] wdata_d;
    logic [3:0]  wstrb_q;
    logic [3:0]  wstrb_d;
    logic        awready_q;
    logic        awready_d;
    logic        wready_q;
    logic        wready_d;
    logic        bvalid_q;
    logic        bvalid_d;
    logic [1:0]  bresp_q;
    logic [1:0]  bresp_d;
    logic        arready_q;
    logic        arready_d;
    logic        rvalid_q;
    logic        rvalid_d;
    logic [1:0]  rresp_q;
    logic [1:0]  rresp_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        wr_fire;

    always_comb begin
        wst_d     = wst_q;
        aw_got_d  = aw_got_q;
        w_got_d   = w_got_q;
        waddr_d   = waddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        clr       = updown_counter_pkg::EVT_RST;
        ena_d     = ena_q;
        wr_fire   = 1'b0;
        if (s_axi_awvalid && awready_q) begin
            aw_got_d = 1'b1;
            waddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_got_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        case (wst_q)
            updown_counter_pkg::W_IDLE: begin
                if (aw_got_q && w_got_q) begin
                    wr_fire  = 1'b1;
                    aw_got_d = 1'b0;
                    w_got_d  = 1'b0;
                    bvalid_d = 1'b1;
                    wst_d    = updown_counter_pkg::W_RESP;
                    bresp_d  = is_mapped(waddr_q) ? updown_counter_pkg::RESP_OKAY
                                                  : updown_counter_pkg::RESP_SLVERR;
                end
            end
            updown_counter_pkg::W_RESP: begin
                if (s_axi_bready) begin
                    bvalid_d = 1'b0;
                    wst_d    = updown_counter_pkg::W_IDLE;
                end
            end
            default: begin
                wst_d = updown_counter_pkg::W_IDLE;
            end
        endcase
        if (wr_fire && wstrb_q[0]) begin
            if (waddr_q == updown_counter_pkg::OFS_CLEAR) begin
                clr = wdata_q[2:0];
            end
            if (waddr_q == updown_counter_pkg::OFS_ENABLE) begin
                ena_d = wdata_q[2:0];
            end
        end
        awready_d = !aw_got_d;
        wready_d  = !w_got_d;
    end

    always_comb begin
        rst_d     = rst_q;
        arready_d = arready_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        case (rst_q)
            updown_counter_pkg::R_IDLE: begin
                arready_d = 1'b1;
                if (s_axi_arvalid && arready_q) begin
                    arready_d = 1'b0;
                    rvalid_d  = 1'b1;
                    rst_d     = updown_counter_pkg::R_DATA;
                    rresp_d   = is_mapped(s_axi_araddr) ? updown_counter_pkg::RESP_OKAY
                                                        : updown_counter_pkg::RESP_SLVERR;
                    rdata_d   = updown_counter_pkg::RDATA_RST;
                    case (s_axi_araddr)
                        updown_counter_pkg::OFS_STATE: begin
                            rdata_d[updown_counter_pkg::ST_COUNT_LSB +: 4] = count_q;
                            rdata_d[updown_counter_pkg::ST_FLAG_BIT]  = flag_q;
                            rdata_d[updown_counter_pkg::ST_PULSE_BIT] = pulse_q;
                            rdata_d[updown_counter_pkg::ST_DIR_BIT]   = direction_sel;
                            rdata_d[updown_counter_pkg::ST_LOAD_BIT]  = preset_load_n;
                        end
                        updown_counter_pkg::OFS_EVENT: begin
                            rdata_d[2:0] = evt_q;
                        end
                        updown_counter_pkg::OFS_ENABLE: begin
                            rdata_d[2:0] = ena_q;
                        end
                        default: begin
                            rdata_d = updown_counter_pkg::RDATA_RST;
                        end
                    endcase
                end
            end
            updown_counter_pkg::R_DATA: begin
                if (s_axi_rready) begin
                    rvalid_d  = 1'b0;
                    arready_d = 1'b1;
                    rst_d     = updown_counter_pkg::R_IDLE;
                end
            end
            default: begin
                rst_d = updown_counter_pkg::R_IDLE;
            end
        endcase
    end

    always_comb begin
        hit.terminal = flag_d & ~flag_q;
        hit.cascade  = ~pulse_d & pulse_q;
        hit.preset   = load_fall;
        // a new event beats a clear landing in the same cycle
        evt_d = (evt_q & ~clr) | hit;
        irq_d = |(evt_d & ena_d);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wst_q     <= updown_counter_pkg::W_IDLE;
            rst_q     <= updown_counter_pkg::R_IDLE;
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            waddr_q   <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= updown_counter_pkg::RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rresp_q   <= updown_counter_pkg::RESP_OKAY;
            rdata_q   <= updown_counter_pkg::RDATA_RST;
            evt_q     <= updown_counter_pkg::EVT_RST;
            ena_q     <= updown_counter_pkg::EVT_RST;
            irq_q     <= 1'b0;
        end else begin
            wst_q     <= wst_d;
            rst_q     <= rst_d;
            aw_got_q  <= aw_got_d;
            w_got_q   <= w_got_d;
            waddr_q   <= waddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
            evt_q     <= evt_d;
            ena_q     <= ena_d;
            irq_q     <= irq_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;
    assign irq           = irq_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence seq_counting;
        preset_load_n && !count_enable_n && cp_rise;
    endsequence

    sequence seq_armed;
        preset_load_n && !count_enable_n && terminal_flag && cp_fall;
    endsequence

    chk_wrap_up: assert property ( // R1
        seq_counting and (!direction_sel && count_q == updown_counter_pkg::CNT_TOP)
        |=> count_q == updown_counter_pkg::CNT_BOTTOM)
        else $error("count did not wrap from 15 to 0");

    chk_preset_copy: assert property ( // R2 R3
        !preset_load_n |=> count_q == $past(preset_value))
        else $error("preset value not loaded");

    chk_no_edge_hold: assert property ( // R4
        preset_load_n && !cp_rise |=> count_q == $past(count_q))
        else $error("count changed without a clock rise");

    chk_disabled_hold: assert property ( // R5
        preset_load_n && count_enable_n |=> $stable(count_q))
        else $error("count changed while disabled");

    chk_count_down: assert property ( // R6
        seq_counting and direction_sel
        |=> count_q == 4'($past(count_q) - updown_counter_pkg::CNT_STEP))
        else $error("count down step wrong");

    chk_flag_decode: assert property ( // R8 R9 R10
        1'b1 |=> terminal_flag ==
            ((!$past(direction_sel) && count_q == updown_counter_pkg::CNT_TOP) ||
             ($past(direction_sel) && count_q == updown_counter_pkg::CNT_BOTTOM)))
        else $error("terminal flag does not match count and direction");

    chk_pulse_low: assert property ( // R12
        seq_armed |=> !cascade_pulse_n)
        else $error("cascade pulse missing after clock fall");

    chk_pulse_forced: assert property ( // R13
        !preset_load_n || count_enable_n || !terminal_flag |=> cascade_pulse_n)
        else $error("cascade pulse not forced high");

    chk_pulse_release: assert property ( // R16
        !cascade_pulse_n && cp_rise |=> cascade_pulse_n)
        else $error("cascade pulse not released on clock rise");

    chk_resume_preset: assert property ( // R18
        !preset_load_n ##1 (seq_counting and !direction_sel)
        |=> count_q == 4'($past(preset_value, 2) + updown_counter_pkg::CNT_STEP))
        else $error("count did not resume from preset value");

endmodule : updown_counter

// File: cp_source.sv
// count clock source standing in for the upstream control logic
`timescale 1ns/1ps
module cp_source (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       start,
    input  wire logic       enable_n,
    input  wire logic       flag,
    input  wire logic       carry_n,
    output logic            count_clock,
    output logic            busy,
    output logic      [3:0] ripple_cnt,
    output logic      [3:0] ahead_cnt
);
    logic [2:0] ph_q;
    logic [2:0] ph_d;
    logic       prev_q;

    // ripple stage: the carry output is the clock of the next stage
    always_ff @(posedge carry_n or negedge rst_b) begin
        if (!rst_b) begin
            ripple_cnt <= 4'h0;
        end else begin
            ripple_cnt <= ripple_cnt + 4'h1;
        end
    end

    // look-ahead stage: flag is sampled on clk, never used as a clock
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_q    <= 1'b0;
            ahead_cnt <= 4'h0;
        end else begin
            prev_q <= count_clock;
            if (count_clock && !prev_q && !(enable_n || !flag)) begin
                ahead_cnt <= ahead_cnt + 4'h1;
            end
        end
    end

    // one pulse per start: high two cycles, low at least two more
    always_comb begin
        ph_d = ph_q;
        if (ph_q != 3'h0) begin
            ph_d = ph_q - 3'h1;
        end else if (start) begin
            ph_d = 3'h4;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ph_q <= 3'h0;
        end else begin
            ph_q <= ph_d;
        end
    end

    // long low phase lets a falling carry reach the counter before the next rise
    assign count_clock = (ph_q >= 3'h3);
    assign busy        = (ph_q != 3'h0);
endmodule : cp_source

// File: tb.sv
// self-checking testbench of the up/down counter
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        start = 1'b0;
    logic        busy;
    logic        count_clock;
    logic        count_enable_n = 1'b0;
    logic        direction_sel = 1'b0;
    logic        preset_load_n = 1'b1;
    logic [3:0]  preset_value = 4'h0;
    logic [3:0]  count_value;
    logic        terminal_flag;
    logic        cascade_pulse_n;
    logic        irq;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [31:0] d;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [1:0]  r;
    logic [3:0]  ripple_cnt;
    logic [3:0]  ahead_cnt;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    int          fails = 0;
    int          compares = 0;

    always #12.5 clk = ~clk;

    cp_source i_src (.clk(clk), .rst_b(rst_b), .start(start), .enable_n(count_enable_n),
        .flag(terminal_flag), .carry_n(cascade_pulse_n), .count_clock(count_clock),
        .busy(busy), .ripple_cnt(ripple_cnt), .ahead_cnt(ahead_cnt));

    updown_counter i_dut (.clk(clk), .rst_b(rst_b), .count_clock(count_clock),
        .count_enable_n(count_enable_n), .direction_sel(direction_sel),
        .preset_load_n(preset_load_n), .preset_value(preset_value),
        .count_value(count_value), .terminal_flag(terminal_flag),
        .cascade_pulse_n(cascade_pulse_n), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic pulse(input logic drop_preset = 1'b0);
        int n;
        @(posedge clk) start <= 1'b1;
        @(posedge clk) start <= 1'b0;
        // preset lifts at the edge just before the clock rise is seen
        if (drop_preset) begin
            preset_load_n <= 1'b1;
        end
        @(posedge clk);
        n = 0;
        while (busy && n < 20) begin
            @(posedge clk);
            n++;
        end
        cyc(3);
    endtask : pulse

    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        int n;
        @(posedge clk);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && n < 50);
        rs = bresp;
        bready <= 1'b0;
        if (n >= 50) fails++;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n;
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && n < 50);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        if (n >= 50) fails++;
    endtask : rd

    task automatic stop_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_preset;
        preset_value <= 4'he; preset_load_n <= 1'b0;
        cyc(3);
        `CHK("preset count", 4'he, count_value)
        pulse();
        `CHK("count under preset", 4'he, count_value)
        `CHK("pulse under preset", 1'b1, cascade_pulse_n)
        `CHK("flag at 14", 1'b0, terminal_flag)
        pulse(1'b1);
        `CHK("resume from preset", 4'hf, count_value)
        `CHK("flag at 15 up", 1'b1, terminal_flag)
        `CHK("pulse low after fall", 1'b0, cascade_pulse_n)
        $display("test preset done");
    endtask : t_preset

    task automatic t_wrap;
        pulse();
        `CHK("wrap up", 4'h0, count_value)
        `CHK("pulse high after rise", 1'b1, cascade_pulse_n)
        `CHK("ripple stage carry", 4'h1, ripple_cnt)
        `CHK("look-ahead stage carry", 4'h1, ahead_cnt)
        direction_sel <= 1'b1;
        cyc(3);
        `CHK("flag at 0 down", 1'b1, terminal_flag)
        count_enable_n <= 1'b1;
        pulse();
        pulse();
        `CHK("hold count", 4'h0, count_value)
        `CHK("flag ignores enable", 1'b1, terminal_flag)
        `CHK("pulse off when disabled", 1'b1, cascade_pulse_n)
        `CHK("look-ahead held", 4'h1, ahead_cnt)
        count_enable_n <= 1'b0;
        pulse();
        `CHK("wrap down", 4'hf, count_value)
        `CHK("look-ahead borrow", 4'h2, ahead_cnt)
        `CHK("no late ripple pulse", 4'h1, ripple_cnt)
        pulse();
        `CHK("count down", 4'he, count_value)
        `CHK("flag off at 14 down", 1'b0, terminal_flag)
        $display("test wrap done");
    endtask : t_wrap

    task automatic t_regs;
        rd(updown_counter_pkg::OFS_STATE, d, r);
        `CHK("state reg", 32'h0000_00ee, d)
        rd(updown_counter_pkg::OFS_EVENT, d, r);
        `CHK("event reg", 32'h0000_0007, d)
        `CHK("irq masked", 1'b0, irq)
        wr(updown_counter_pkg::OFS_ENABLE, 32'h1, r);
        `CHK("write resp", updown_counter_pkg::RESP_OKAY, r)
        cyc(2);
        `CHK("irq raised", 1'b1, irq)
        wr(updown_counter_pkg::OFS_CLEAR, 32'h7, r);
        cyc(2);
        `CHK("irq cleared", 1'b0, irq)
        rd(updown_counter_pkg::OFS_EVENT, d, r);
        `CHK("event cleared", 32'h0, d)
        rd(8'h10, d, r);
        `CHK("unmapped read", updown_counter_pkg::RESP_SLVERR, r)
        `CHK("unmapped read data", 32'h0, d)
        wr(8'h10, 32'h1, r);
        `CHK("unmapped write", updown_counter_pkg::RESP_SLVERR, r)
        $display("test registers done");
    endtask : t_regs

    task automatic t_reset;
        cyc(5);
        rst_b <= 1'b1;
        cyc(3);
        `CHK("reset count", 4'h0, count_value)
        `CHK("reset flag", 1'b0, terminal_flag)
        `CHK("reset pulse", 1'b1, cascade_pulse_n)
        $display("test reset done");
    endtask : t_reset

    initial begin
        t_reset();
        t_preset();
        t_wrap();
        t_regs();
        stop_test();
    end

    // the whole sequence needs well under a thousand cycles
    initial begin
        #(25 * 5000);
        fails++;
        stop_test();
    end
endmodule : tb
